//--- src/pch_cfg_regs.sv
`timescale 1ns/1ps
`include "pch_defines.svh"
module pch_cfg_regs
	import pch_pkg::*;
#(
	parameter pch_word_t VENDOR_ID = 16'h1234, // arbitrary value
	parameter pch_word_t DEVICE_ID = 16'h5678 // arbitrary value
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CFG_STB,
	input wire logic CFG_IDSEL,
	input wire logic [3:0] CFG_CMD,
	input wire logic [7:0] CFG_ADDR,
	input wire logic [3:0] CFG_BE_N,
	input wire logic [31:0] CFG_WDATA,
	output logic CFG_ACK,
	output logic [31:0] CFG_RDATA,
	input wire logic DEV_STB,
	input wire logic [1:0] DEV_ADDR,
	output logic DEV_ACK,
	output logic [7:0] DEV_RDATA,
	input wire logic IO_HIT_IN,
	input wire logic MEM_HIT_IN,
	output logic IO_CLAIM,
	output logic MEM_CLAIM,
	input wire logic MST_REQ_IN,
	input wire logic [3:0] MST_CMD_IN,
	output logic MST_REQ,
	output logic [3:0] MST_CMD,
	output logic IO_ALLOW,
	output logic MEM_ALLOW,
	output logic MST_ALLOW,
	output logic PAR_ALLOW,
	output logic SERR_ALLOW,
	output logic MWI_ALLOW
);
	// ==========================================================
	// Access qualification and decode
	logic cfg_rd;
	logic cfg_wr;
	logic cfg_ok;
	logic hit_id;
	logic hit_cmd;
	logic we_lo;
	logic we_hi;
	logic mirror_ok;
	pch_sel_t sel;
	pch_word_t cmd;
	pch_byte_t cmd_lo;
	pch_byte_t cmd_hi;
	logic [31:0] rdata_nxt;
	pch_byte_t dev_nxt;
	logic [3:0] mcmd_nxt;

	assign cfg_rd = CFG_CMD == `PCH_CMD_CFG_READ;
	assign cfg_wr = CFG_CMD == `PCH_CMD_CFG_WRITE;
	assign cfg_ok = CFG_STB && CFG_IDSEL && (CFG_ADDR[1:0] == `PCH_ALIGN_ZERO)
		&& (cfg_rd || cfg_wr);
	assign hit_id = CFG_ADDR == `PCH_OFF_ID;
	assign hit_cmd = CFG_ADDR == `PCH_OFF_CMD;
	// Only the command bytes take writes; identity and reserved space drop data
	assign we_lo = cfg_ok && cfg_wr && hit_cmd && !CFG_BE_N[0];
	assign we_hi = cfg_ok && cfg_wr && hit_cmd && !CFG_BE_N[1];

	assign sel = !hit_id && !hit_cmd ? PCH_SEL_ZERO : (hit_id ? PCH_SEL_ID : PCH_SEL_CMD);

	// ==========================================================
	// Command word storage
	pch_wbyte #(.MASK(`PCH_CMD_MASK_LO)) u_cmd_lo (
		.clk(CLK),
		.rst_n(RST_N),
		.we(we_lo),
		.wdata(CFG_WDATA[7:0]),
		.q(cmd_lo)
	);
	pch_wbyte #(.MASK(`PCH_CMD_MASK_HI)) u_cmd_hi (
		.clk(CLK),
		.rst_n(RST_N),
		.we(we_hi),
		.wdata(CFG_WDATA[15:8]),
		.q(cmd_hi)
	);
	assign cmd = {cmd_hi, cmd_lo};

	// ==========================================================
	// Read data selection
	always_comb begin
		case (sel)
			PCH_SEL_ID: rdata_nxt = {DEVICE_ID, VENDOR_ID};
			PCH_SEL_CMD: rdata_nxt = {`PCH_ZERO16, cmd};
			default: rdata_nxt = `PCH_ZERO32;
		endcase
	end

	// Device-space mirror of the identity bytes
	assign mirror_ok = DEV_STB && (cmd[`PCH_BIT_IO] || cmd[`PCH_BIT_MEM]);
	always_comb begin
		case (DEV_ADDR)
			2'h0: dev_nxt = VENDOR_ID[7:0];
			2'h1: dev_nxt = VENDOR_ID[15:8];
			2'h2: dev_nxt = DEVICE_ID[7:0];
			default: dev_nxt = DEVICE_ID[15:8];
		endcase
	end

	assign mcmd_nxt = (MST_CMD_IN == `PCH_MCMD_MWI && !cmd[`PCH_BIT_MWI]) ?
		`PCH_MCMD_MWR : MST_CMD_IN;

	// ==========================================================
	// Registered outputs
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			CFG_ACK <= 1'b0;
			CFG_RDATA <= `PCH_ZERO32;
			DEV_ACK <= 1'b0;
			DEV_RDATA <= `PCH_ZERO8;
		end else begin
			CFG_ACK <= cfg_ok;
			CFG_RDATA <= (cfg_ok && cfg_rd) ? rdata_nxt : `PCH_ZERO32;
			DEV_ACK <= mirror_ok;
			DEV_RDATA <= mirror_ok ? dev_nxt : `PCH_ZERO8;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			IO_CLAIM <= 1'b0;
			MEM_CLAIM <= 1'b0;
			MST_REQ <= 1'b0;
			MST_CMD <= `PCH_MCMD_MWR;
		end else begin
			IO_CLAIM <= IO_HIT_IN && cmd[`PCH_BIT_IO];
			MEM_CLAIM <= MEM_HIT_IN && cmd[`PCH_BIT_MEM];
			MST_REQ <= MST_REQ_IN && cmd[`PCH_BIT_MST];
			MST_CMD <= mcmd_nxt;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			IO_ALLOW <= 1'b0;
			MEM_ALLOW <= 1'b0;
			MST_ALLOW <= 1'b0;
			PAR_ALLOW <= 1'b0;
			SERR_ALLOW <= 1'b0;
			MWI_ALLOW <= 1'b0;
		end else begin
			IO_ALLOW <= cmd[`PCH_BIT_IO];
			MEM_ALLOW <= cmd[`PCH_BIT_MEM];
			MST_ALLOW <= cmd[`PCH_BIT_MST];
			PAR_ALLOW <= cmd[`PCH_BIT_PAR];
			SERR_ALLOW <= cmd[`PCH_BIT_SERR];
			MWI_ALLOW <= cmd[`PCH_BIT_MWI];
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	logic unq;
	logic rd_id;
	logic rd_rsvd;
	logic rd_cmd;
	assign unq = CFG_STB && !cfg_ok;
	assign rd_id = cfg_ok && cfg_rd && hit_id;
	assign rd_rsvd = cfg_ok && cfg_rd && !hit_id && !hit_cmd;
	assign rd_cmd = cfg_ok && cfg_rd && hit_cmd;

	sequence s_cfg_wr_cmd;
		cfg_ok && cfg_wr && hit_cmd && !CFG_BE_N[0];
	endsequence
	sequence s_cmd_loaded;
		cmd_lo == ($past(CFG_WDATA[7:0]) & `PCH_CMD_MASK_LO);
	endsequence

	property p_cfg_refuse;
		unq |=> !CFG_ACK;
	endproperty
	a_cfg_refuse: assert property (p_cfg_refuse) else $error("unqualified access acked");

	property p_cfg_take;
		cfg_ok |=> CFG_ACK;
	endproperty
	a_cfg_take: assert property (p_cfg_take) else $error("qualified access not acked");

	property p_id_read;
		rd_id |=> CFG_RDATA == {DEVICE_ID, VENDOR_ID};
	endproperty
	a_id_read: assert property (p_id_read) else $error("identity read wrong");

	property p_rsvd_zero;
		rd_rsvd |=> CFG_RDATA == `PCH_ZERO32;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");

	property p_cmd_read;
		rd_cmd |=> CFG_RDATA[15:0] == $past(cmd) && CFG_RDATA[31:16] == `PCH_ZERO16;
	endproperty
	a_cmd_read: assert property (p_cmd_read) else $error("command read wrong");

	property p_cmd_write;
		s_cfg_wr_cmd |=> s_cmd_loaded;
	endproperty
	a_cmd_write: assert property (p_cmd_write) else $error("command write lost");

	property p_rsvd_bits;
		(cmd_lo & ~`PCH_CMD_MASK_LO) == `PCH_ZERO8 && (cmd_hi & ~`PCH_CMD_MASK_HI) == `PCH_ZERO8;
	endproperty
	a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved command bit set");

	property p_reset;
		@(posedge CLK) disable iff (1'b0) !RST_N |=> cmd == `PCH_CMD_RESET && !MST_REQ;
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not clear command");

	property p_mirror;
		DEV_STB |=> DEV_ACK == $past(cmd[`PCH_BIT_IO] || cmd[`PCH_BIT_MEM])
			&& (DEV_ACK || DEV_RDATA == `PCH_ZERO8);
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror gating wrong");

	property p_disconnect;
		cmd == `PCH_CMD_RESET |=> !IO_CLAIM && !MEM_CLAIM && !MST_REQ && !DEV_ACK;
	endproperty
	a_disconnect: assert property (p_disconnect) else $error("claimed while disconnected");

	property p_master_gate;
		MST_REQ |-> $past(cmd[`PCH_BIT_MST]) && $past(MST_REQ_IN);
	endproperty
	a_master_gate: assert property (p_master_gate) else $error("master request ungated");

	property p_decode;
		(IO_HIT_IN || MEM_HIT_IN) |=> IO_CLAIM == $past(IO_HIT_IN && cmd[`PCH_BIT_IO])
			&& MEM_CLAIM == $past(MEM_HIT_IN && cmd[`PCH_BIT_MEM]);
	endproperty
	a_decode: assert property (p_decode) else $error("decode enable wrong");

	property p_mwi;
		MST_CMD_IN == `PCH_MCMD_MWI && !cmd[`PCH_BIT_MWI] |=> MST_CMD == `PCH_MCMD_MWR;
	endproperty
	a_mwi: assert property (p_mwi) else $error("MWI not replaced");
endmodule

//--- src/pch_defines.svh
`ifndef PCH_DEFINES_SVH
`define PCH_DEFINES_SVH

// ==========================================================
// Configuration cycle qualification
`define PCH_CMD_CFG_READ 4'hA
`define PCH_CMD_CFG_WRITE 4'hB
`define PCH_ALIGN_ZERO 2'h0

// ==========================================================
// Configuration offsets (byte address, dword aligned)
`define PCH_OFF_ID 8'h00
`define PCH_OFF_CMD 8'h04

// ==========================================================
// Command word layout
`define PCH_CMD_RESET 16'h0000
`define PCH_CMD_MASK_LO 8'h57
`define PCH_CMD_MASK_HI 8'h01
`define PCH_BIT_IO 0
`define PCH_BIT_MEM 1
`define PCH_BIT_MST 2
`define PCH_BIT_MWI 4
`define PCH_BIT_PAR 6
`define PCH_BIT_SERR 8

// ==========================================================
// Master bus command codes
`define PCH_MCMD_MWR 4'h7
`define PCH_MCMD_MWI 4'hF

`define PCH_ZERO32 32'h0000_0000
`define PCH_ZERO16 16'h0000
`define PCH_ZERO8 8'h00

`endif

//--- src/pch_pkg.sv
package pch_pkg;
	typedef logic [15:0] pch_word_t;
	typedef logic [7:0] pch_byte_t;
	typedef enum logic [1:0] {PCH_SEL_ZERO, PCH_SEL_ID, PCH_SEL_CMD} pch_sel_t;
endpackage

//--- src/pch_wbyte.sv
`timescale 1ns/1ps
`include "pch_defines.svh"
// ==========================================================
// One writable byte; bits outside MASK always hold zero
module pch_wbyte
	import pch_pkg::*;
#(
	parameter pch_byte_t MASK = 8'hFF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire pch_byte_t wdata,
	output pch_byte_t q
);
	pch_byte_t q_r;
	pch_byte_t q_nxt;

	assign q_nxt = we ? (wdata & MASK) : q_r;
	assign q = q_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q_r <= `PCH_ZERO8;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule

//--- sim/pch_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host bridge model issuing configuration cycles
module pch_host (
	input wire logic CLK,
	input wire logic ACK,
	input wire logic [31:0] RDATA,
	output logic STB,
	output logic IDSEL,
	output logic [3:0] CMD,
	output logic [7:0] ADDR,
	output logic [3:0] BE_N,
	output logic [31:0] WDATA
);
	initial begin
		STB = 1'b0;
		IDSEL = 1'b0;
		CMD = 4'h0;
		ADDR = 8'h00;
		BE_N = 4'hF;
		WDATA = 32'h0000_0000;
	end
	// One strobed cycle; afterwards STB and IDSEL drop low and the other released lines show inverted values
	task automatic xfer(input logic sel, input logic [3:0] cmd, input logic [7:0] adr,
		input logic [3:0] be_n, input logic [31:0] wd, output logic ack, output logic [31:0] rd);
		@(posedge CLK);
		STB <= 1'b1;
		IDSEL <= sel;
		CMD <= cmd;
		ADDR <= adr;
		BE_N <= be_n;
		WDATA <= wd;
		@(posedge CLK);
		STB <= 1'b0;
		IDSEL <= 1'b0;
		CMD <= ~cmd;
		BE_N <= ~be_n;
		ADDR <= ~adr;
		WDATA <= ~wd;
		#1;
		ack = ACK;
		rd = RDATA;
	endtask
endmodule

//--- sim/pci_config_header_regs_bench.sv
`timescale 1ns/1ps
`include "pch_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module pci_config_header_regs_bench
	import pch_pkg::*;
;
	localparam pch_word_t VID = 16'hA5C3; // arbitrary value
	localparam pch_word_t DID = 16'h3C5A; // arbitrary value
	localparam logic [31:0] IDW = {DID, VID};
	localparam logic [4:0][12:0] BAD = {13'h1A01, 13'h1704, 13'h1B06, 13'h1B05, 13'h0B04};
	int n_mismatch = 0;
	int tests_run = 0;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic DEV_STB = 1'b0, IO_HIT_IN = 1'b0, MEM_HIT_IN = 1'b0, MST_REQ_IN = 1'b0;
	logic [1:0] DEV_ADDR = 2'h0;
	logic [3:0] MST_CMD_IN = 4'h0;
	logic CFG_STB, CFG_IDSEL, CFG_ACK, DEV_ACK, IO_CLAIM, MEM_CLAIM, MST_REQ, ack;
	logic IO_ALLOW, MEM_ALLOW, MST_ALLOW, PAR_ALLOW, SERR_ALLOW, MWI_ALLOW;
	logic [3:0] CFG_CMD, CFG_BE_N, MST_CMD;
	logic [7:0] CFG_ADDR, DEV_RDATA;
	logic [31:0] CFG_WDATA, CFG_RDATA, rd;
	pch_cfg_regs #(.VENDOR_ID(VID), .DEVICE_ID(DID)) i_dut (.CLK, .RST_N, .CFG_STB,
		.CFG_IDSEL, .CFG_CMD, .CFG_ADDR, .CFG_BE_N, .CFG_WDATA, .CFG_ACK, .CFG_RDATA,
		.DEV_STB, .DEV_ADDR, .DEV_ACK, .DEV_RDATA, .IO_HIT_IN, .MEM_HIT_IN, .IO_CLAIM,
		.MEM_CLAIM, .MST_REQ_IN, .MST_CMD_IN, .MST_REQ, .MST_CMD, .IO_ALLOW, .MEM_ALLOW,
		.MST_ALLOW, .PAR_ALLOW, .SERR_ALLOW, .MWI_ALLOW);
	pch_host i_host (.CLK, .ACK(CFG_ACK), .RDATA(CFG_RDATA), .STB(CFG_STB),
		.IDSEL(CFG_IDSEL), .CMD(CFG_CMD), .ADDR(CFG_ADDR), .BE_N(CFG_BE_N), .WDATA(CFG_WDATA));
	task automatic end_sim();
		$display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		i_host.xfer(1'b1, `PCH_CMD_CFG_WRITE, a, be, d, ack, rd);
		`CHK(ack, 1'b1)
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		i_host.xfer(1'b1, `PCH_CMD_CFG_READ, a, 4'h0, 32'h0000_0000, ack, rd);
		`CHK(ack, 1'b1)
		`CHK(rd, e)
	endtask
	task automatic mrd(input logic [1:0] a, input logic e_ack, input logic [7:0] e);
		@(posedge CLK);
		DEV_STB <= 1'b1;
		DEV_ADDR <= a;
		@(posedge CLK);
		DEV_STB <= 1'b0;
		DEV_ADDR <= ~a;
		#1;
		`CHK(DEV_ACK, e_ack)
		`CHK(DEV_RDATA, e)
	endtask
	// Decode, master and enable outputs expected from the command word c and the master command m
	task automatic path(input logic [3:0] m, input logic [15:0] c);
		logic [12:0] e;
		logic [12:0] g;
		e = {c[0], c[1], c[2], (m == 4'hF && !c[4]) ? 4'h7 : m, c[0], c[1], c[2], c[4], c[6], c[8]};
		@(posedge CLK);
		IO_HIT_IN <= 1'b1;
		MEM_HIT_IN <= 1'b1;
		MST_REQ_IN <= 1'b1;
		MST_CMD_IN <= m;
		@(posedge CLK);
		#1;
		g = {IO_CLAIM, MEM_CLAIM, MST_REQ, MST_CMD, IO_ALLOW, MEM_ALLOW, MST_ALLOW,
			MWI_ALLOW, PAR_ALLOW, SERR_ALLOW};
		`CHK(g, e)
	endtask
	initial begin
		forever #20 CLK = ~CLK;
	end
	initial begin
		repeat (3000) @(posedge CLK);
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		rdc(`PCH_OFF_ID, IDW);
		rdc(`PCH_OFF_CMD, 32'h0000_0000);
		mrd(2'h1, 1'b0, 8'h00);
		path(4'hF, 16'h0000);
		wr(`PCH_OFF_CMD, 4'h0, 32'hFFFF_FFFF);
		rdc(`PCH_OFF_CMD, 32'h0000_0157);
		path(4'hF, 16'h0157);
		wr(`PCH_OFF_ID, 4'h0, 32'h0000_0000);
		rdc(`PCH_OFF_ID, IDW);
		wr(8'h0C, 4'h0, 32'hFFFF_FFFF);
		rdc(8'h0C, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			rdc(8'h18 + 8'(i * 4), 32'h0000_0000);
		end
		rdc(8'h40, 32'h0000_0000);
		wr(`PCH_OFF_CMD, 4'hE, 32'h0000_0001);
		rdc(`PCH_OFF_CMD, 32'h0000_0101);
		path(4'hF, 16'h0101);
		for (int i = 0; i < 4; i++) begin
			mrd(i[1:0], 1'b1, IDW[8 * i +: 8]);
		end
		wr(`PCH_OFF_CMD, 4'h0, 32'h0000_0002);
		mrd(2'h3, 1'b1, DID[15:8]);
		path(4'hF, 16'h0002);
		wr(`PCH_OFF_CMD, 4'h0, 32'h0000_0014);
		path(4'hF, 16'h0014);
		mrd(2'h0, 1'b0, 8'h00);
		for (int i = 0; i < 5; i++) begin
			i_host.xfer(BAD[i][12], BAD[i][11:8], BAD[i][7:0], 4'h0, 32'h0000_0000, ack, rd);
			`CHK({ack, rd}, 33'h0_0000_0000)
		end
		rdc(`PCH_OFF_CMD, 32'h0000_0014);
		@(posedge CLK);
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		rdc(`PCH_OFF_CMD, 32'h0000_0000);
		path(4'hF, 16'h0000);
		end_sim();
	end
endmodule
